// [rtl/cfam_alu.sv]
// ALU datapath for chained compare, find highest set bit, long immediate load and maximum

// ==========================================================
// How it works
// - Copy immediate bit 9 into upper bits
// - Compare source and widened immediate unsigned
// - Fold previous compare, top halfword first
// - Chained compare writes no destination register
// - Compare-style condition decode for chain, max
// - No instruction here touches overflow flag
// - Write index of highest one-bit in halfword
// - Bit 0 gives 0x0000, bit 15 0x000F
// - Empty halfword writes 0x8000
// - Find accepts branch, always, memory update fields
// - Load writes full 16-bit immediate
// - Load has no branch, only memory update
// - Maximum writes larger unsigned source
// - Maximum accepts branch, always, update fields; modulo field unused
// - Plain compare ignores any earlier compare
module cfam_alu #(
   parameter int DATA_W = cfam_pkg::DATA_W
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 clk_en,
   input  wire cfam_pkg::cfam_instr_t instr,
   output cfam_pkg::cfam_result_t    result
);

   // ==========================================================
   // Combinational datapath
   logic [DATA_W-1:0]      imm_wide;
   cfam_pkg::cfam_cmp_t    raw_cmp;
   cfam_pkg::cfam_cmp_t    imm_cmp;
   cfam_pkg::cfam_cmp_t    reg_cmp;
   cfam_pkg::cfam_cmp_t    nxt_cmp;
   cfam_pkg::cfam_cmp_t    cmp_ff;
   logic [DATA_W-1:0]      fhsb_val;
   logic [DATA_W-1:0]      nxt_data;
   logic                   nxt_wr;
   logic                   nxt_br_valid;
   logic                   nxt_br_take;
   logic                   nxt_fm;
   logic                   nxt_exec;
   logic [15:0]            low_half;
   logic [15:0]            hit_vec;
   cfam_pkg::cfam_result_t result_ff;

   // Widen by replicating bit 9
   assign imm_wide = {{(DATA_W-cfam_pkg::IMM_W){instr.imm10[cfam_pkg::IMM_TOP]}},
                      instr.imm10};

   function automatic cfam_pkg::cfam_cmp_t ucmp(input logic [DATA_W-1:0] a,
                                                input logic [DATA_W-1:0] b);
      if (a == b) begin
         return cfam_pkg::CFAM_CMP_EQ;
      end else if (a < b) begin
         return cfam_pkg::CFAM_CMP_LT;
      end else begin
         return cfam_pkg::CFAM_CMP_GT;
      end
   endfunction : ucmp

   assign imm_cmp = ucmp(instr.rsa_val, imm_wide);
   assign reg_cmp = ucmp(instr.rsa_val, instr.rsb_val);

   // Priority encoder: one term per bit, scanned from bit 0 upward
   assign low_half = instr.rsa_val[15:0];
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_hit
         if (gi == 15) begin : g_top
            assign hit_vec[gi] = low_half[gi];
         end else begin : g_low
            assign hit_vec[gi] = low_half[gi] & ~(|low_half[15:gi+1]);
         end
      end
   endgenerate

   always_comb begin
      fhsb_val = cfam_pkg::FHSB_EMPTY;
      for (int i = 0; i < 16; i++) begin
         if (hit_vec[i]) begin
            fhsb_val = DATA_W'(i);
         end
      end
   end

   always_comb begin
      raw_cmp = cfam_pkg::CFAM_CMP_EQ;
      case (instr.op)
         cfam_pkg::CFAM_OP_REG_COMPARE: raw_cmp = reg_cmp;
         cfam_pkg::CFAM_OP_FIRST_IMM:   raw_cmp = imm_cmp;
         cfam_pkg::CFAM_OP_CHAIN_IMM:   raw_cmp = imm_cmp;
         cfam_pkg::CFAM_OP_MAX:   raw_cmp = reg_cmp;
         default:                 raw_cmp = cfam_pkg::CFAM_CMP_EQ;
      endcase
   end

   // Chained outcome: a difference in a higher halfword dominates
   always_comb begin
      nxt_cmp = cmp_ff;
      if (instr.valid) begin
         case (instr.op)
            cfam_pkg::CFAM_OP_CHAIN_IMM: begin
               nxt_cmp = (cmp_ff == cfam_pkg::CFAM_CMP_EQ) ? raw_cmp : cmp_ff;
            end
            cfam_pkg::CFAM_OP_REG_COMPARE,
            cfam_pkg::CFAM_OP_FIRST_IMM,
            cfam_pkg::CFAM_OP_MAX: begin
               nxt_cmp = raw_cmp;
            end
            default: nxt_cmp = cmp_ff;
         endcase
      end
   end

   function automatic logic cond_hit(input cfam_pkg::cfam_cond_t c,
                                     input cfam_pkg::cfam_cmp_t r);
      case (c)
         cfam_pkg::CFAM_BC_EQ:  return r == cfam_pkg::CFAM_CMP_EQ;
         cfam_pkg::CFAM_BC_NE:  return r != cfam_pkg::CFAM_CMP_EQ;
         cfam_pkg::CFAM_BC_LT:  return r == cfam_pkg::CFAM_CMP_LT;
         cfam_pkg::CFAM_BC_GE:  return r != cfam_pkg::CFAM_CMP_LT;
         cfam_pkg::CFAM_BC_GT:  return r == cfam_pkg::CFAM_CMP_GT;
         cfam_pkg::CFAM_BC_LE:  return r != cfam_pkg::CFAM_CMP_GT;
         cfam_pkg::CFAM_BC_ALW: return 1'b1;
         default:               return 1'b0;
      endcase
   endfunction : cond_hit

   // Find uses result==0 style test: EQ means zero result
   always_comb begin
      nxt_data     = '0;
      nxt_wr       = 1'b0;
      nxt_br_valid = 1'b0;
      nxt_br_take  = 1'b0;
      nxt_fm       = 1'b0;
      nxt_exec     = 1'b0;
      if (instr.valid) begin
         case (instr.op)
            cfam_pkg::CFAM_OP_REG_COMPARE,
            cfam_pkg::CFAM_OP_FIRST_IMM: begin
               nxt_br_valid = instr.cond != cfam_pkg::CFAM_BC_NONE;
               nxt_br_take  = cond_hit(instr.cond, nxt_cmp);
               nxt_exec     = instr.always_execute_flag;
            end
            cfam_pkg::CFAM_OP_CHAIN_IMM: begin
               // No destination write, branch only
               nxt_br_valid = instr.cond != cfam_pkg::CFAM_BC_NONE;
               nxt_br_take  = cond_hit(instr.cond, nxt_cmp);
            end
            cfam_pkg::CFAM_OP_FHSB: begin
               nxt_data     = fhsb_val;
               nxt_wr       = 1'b1;
               nxt_fm       = instr.update_fast_memory_flag;
               nxt_exec     = instr.always_execute_flag;
               nxt_br_valid = instr.cond != cfam_pkg::CFAM_BC_NONE;
               nxt_br_take  = cond_hit(instr.cond,
                                       (fhsb_val == '0) ? cfam_pkg::CFAM_CMP_EQ
                                                        : cfam_pkg::CFAM_CMP_GT);
            end
            cfam_pkg::CFAM_OP_LIMM: begin
               nxt_data = instr.long_immediate;
               nxt_wr   = 1'b1;
               nxt_fm   = instr.update_fast_memory_flag;
            end
            cfam_pkg::CFAM_OP_MAX: begin
               nxt_data     = (reg_cmp == cfam_pkg::CFAM_CMP_LT) ? instr.rsb_val
                                                                 : instr.rsa_val;
               nxt_wr       = 1'b1;
               nxt_fm       = instr.update_fast_memory_flag;
               nxt_exec     = instr.always_execute_flag;
               nxt_br_valid = instr.cond != cfam_pkg::CFAM_BC_NONE;
               nxt_br_take  = cond_hit(instr.cond, reg_cmp);
            end
            default: nxt_wr = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Compare state between instructions
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cmp_ff <= cfam_pkg::CMP_RST;
      end else if (clk_en) begin
         cmp_ff <= nxt_cmp;
      end
   end

   // ==========================================================
   // Registered result
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         result_ff <= '0;
      end else if (clk_en) begin
         result_ff.wr_en               <= nxt_wr;
         result_ff.rd                  <= instr.rd;
         result_ff.data                <= nxt_data;
         result_ff.fm_update           <= nxt_fm & nxt_wr;
         result_ff.br_valid            <= nxt_br_valid;
         result_ff.br_take             <= nxt_br_take & nxt_br_valid;
         result_ff.always_execute_flag <= nxt_exec;
         result_ff.ovf_write           <= 1'b0;
         result_ff.cmp_state           <= nxt_cmp;
      end
   end

   assign result = result_ff;

   // ==========================================================
   // Checks
   sequence s_fhsb_issue;
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_FHSB;
   endsequence

   chk_ovf_never_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !result.ovf_write) else $error("overflow write seen");

   chk_fhsb_empty: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_fhsb_issue and (instr.rsa_val[15:0] == 16'h0000) |=> result.data == 16'h8000)
      else $error("empty find value wrong");

   chk_fhsb_top: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_fhsb_issue and instr.rsa_val[15] |=> result.data == 16'h000f && result.wr_en)
      else $error("bit 15 find wrong");

   chk_fhsb_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_fhsb_issue and (instr.rsa_val[15:0] != 16'h0000) |=>
      result.data < 16'h0010 && $past(instr.rsa_val[15:0]) >> result.data == 16'h0001)
      else $error("find index wrong");

   chk_chain_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_CHAIN_IMM |=> !result.wr_en)
      else $error("chained compare wrote register");

   chk_chain_fold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_CHAIN_IMM
      && cmp_ff != cfam_pkg::CFAM_CMP_EQ |=> result.cmp_state == $past(cmp_ff))
      else $error("chain lost higher halfword");

   chk_chain_imm: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_CHAIN_IMM
      && cmp_ff == cfam_pkg::CFAM_CMP_EQ && instr.imm10[9] && instr.rsa_val == 16'hffff
      && instr.imm10 == 10'h3ff |=> result.cmp_state == cfam_pkg::CFAM_CMP_EQ)
      else $error("immediate widening wrong");

   chk_max_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_MAX |=>
      result.data >= $past(instr.rsa_val) && result.data >= $past(instr.rsb_val))
      else $error("maximum wrong");

   chk_limm_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_LIMM |=>
      result.data == $past(instr.long_immediate) && !result.br_valid)
      else $error("long immediate wrong");

   chk_plain_fresh: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_REG_COMPARE
      && instr.rsa_val == instr.rsb_val |=> cmp_ff == cfam_pkg::CFAM_CMP_EQ)
      else $error("plain compare used history");

   chk_max_pick: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_MAX |=>
      result.data == $past(instr.rsa_val) || result.data == $past(instr.rsb_val))
      else $error("maximum not a source");

   chk_limm_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_LIMM |=>
      result.fm_update == $past(instr.update_fast_memory_flag) && result.wr_en)
      else $error("long immediate update wrong");

   chk_first_lower: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_FIRST_IMM
      && instr.rsa_val < imm_wide |=> result.cmp_state == cfam_pkg::CFAM_CMP_LT)
      else $error("immediate compare order wrong");

   // ==========================================================
   // Idle and freeze checks
   // An idle slot must not disturb a chain that is half done
   chk_idle_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && !instr.valid |=>
      !result.wr_en && !result.br_valid && result.cmp_state == $past(cmp_ff))
      else $error("idle slot changed state");

   chk_hold_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !clk_en |=> $stable(result) && $stable(cmp_ff))
      else $error("state moved while frozen");

   // ==========================================================
   // Two-step chain
   // Equal top halfword, an idle gap, then a lower halfword that is above
   sequence s_top_equal;
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_FIRST_IMM
      && imm_cmp == cfam_pkg::CFAM_CMP_EQ;
   endsequence

   sequence s_chain_above;
      clk_en && instr.valid && instr.op == cfam_pkg::CFAM_OP_CHAIN_IMM
      && imm_cmp == cfam_pkg::CFAM_CMP_GT;
   endsequence

   chk_chain_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_top_equal ##1 !instr.valid ##1 s_chain_above |=>
      result.cmp_state == cfam_pkg::CFAM_CMP_GT)
      else $error("chained lower halfword ignored");

endmodule : cfam_alu

// [rtl/cfam_pkg.sv]
// Package: opcodes, field layouts, reset values and result structs for the compare/find/max ALU
package cfam_pkg;

   // ==========================================================
   // Widths
   localparam int DATA_W     = 16;
   localparam int REG_IDX_W  = 6;
   localparam int IMM_W      = 10;
   localparam int IMM_TOP    = 9;
   localparam int COND_W     = 3;
   localparam int MOD_W      = 4;
   localparam int IDX_W      = 4;

   // ==========================================================
   // Fixed result values
   localparam logic [15:0] FHSB_EMPTY = 16'h8000;
   localparam logic [15:0] RESULT_RST = 16'h0000;

   // ==========================================================
   // Operation select
   typedef enum logic [2:0] {
      CFAM_OP_NONE        = 3'b000,
      CFAM_OP_REG_COMPARE = 3'b001,
      CFAM_OP_FIRST_IMM   = 3'b010,
      CFAM_OP_CHAIN_IMM   = 3'b011,
      CFAM_OP_FHSB        = 3'b100,
      CFAM_OP_LIMM        = 3'b101,
      CFAM_OP_MAX         = 3'b110
   } cfam_op_t;

   // Compare outcome carried between instructions
   typedef enum logic [1:0] {
      CFAM_CMP_EQ = 2'b00,
      CFAM_CMP_LT = 2'b01,
      CFAM_CMP_GT = 2'b10
   } cfam_cmp_t;

   // Compare-style branch conditions
   typedef enum logic [2:0] {
      CFAM_BC_NONE = 3'b000,
      CFAM_BC_EQ   = 3'b001,
      CFAM_BC_NE   = 3'b010,
      CFAM_BC_LT   = 3'b011,
      CFAM_BC_GE   = 3'b100,
      CFAM_BC_GT   = 3'b101,
      CFAM_BC_LE   = 3'b110,
      CFAM_BC_ALW  = 3'b111
   } cfam_cond_t;

   localparam cfam_cmp_t CMP_RST = CFAM_CMP_EQ;

   // ==========================================================
   // Decoded instruction in
   typedef struct packed {
      logic                 valid;
      cfam_op_t             op;
      logic [REG_IDX_W-1:0] rd;
      logic [DATA_W-1:0]    rsa_val;
      logic [DATA_W-1:0]    rsb_val;
      logic [IMM_W-1:0]     imm10;
      logic [DATA_W-1:0]    long_immediate;
      cfam_cond_t           cond;
      logic                 always_execute_flag;
      logic                 update_fast_memory_flag;
      logic [MOD_W-1:0]     modulo_width_select;
   } cfam_instr_t;

   // Result out
   typedef struct packed {
      logic                 wr_en;
      logic [REG_IDX_W-1:0] rd;
      logic [DATA_W-1:0]    data;
      logic                 fm_update;
      logic                 br_valid;
      logic                 br_take;
      logic                 always_execute_flag;
      logic                 ovf_write;
      cfam_cmp_t            cmp_state;
   } cfam_result_t;

endpackage : cfam_pkg

// [tb/cfam_alu_tb.sv]
// Self-checking bench for the compare, find, load and maximum datapath
module cfam_alu_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                   ref_clk = 1'b0;
   logic                   rst_n   = 1'b0;
   logic                   clk_en  = 1'b1;
   cfam_pkg::cfam_instr_t  instr;
   cfam_pkg::cfam_result_t res;
   cfam_pkg::cfam_result_t r;
   int                     failures = 0;
   int                     n_tests  = 0;

   always #12.5 ref_clk = ~ref_clk;

   cfam_core_model model (.ref_clk(ref_clk), .instr(instr), .result(res));
   cfam_alu uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .instr(instr), .result(res));

   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic cfam_pkg::cfam_instr_t mk(cfam_pkg::cfam_op_t op, logic [15:0] a,
      logic [15:0] b, logic [9:0] imm, cfam_pkg::cfam_cond_t c);
      mk = '0;
      mk.valid = 1'b1;
      mk.op = op;
      mk.rd = 6'h2a;
      mk.rsa_val = a;
      mk.rsb_val = b;
      mk.imm10 = imm;
      mk.long_immediate = a;
      mk.cond = c;
      mk.always_execute_flag = 1'b1;
      mk.update_fast_memory_flag = 1'b1;
      mk.modulo_width_select = 4'h5;
   endfunction : mk

   function automatic cfam_pkg::cfam_cmp_t rel(logic [15:0] a, logic [15:0] b);
      rel = (a == b) ? cfam_pkg::CFAM_CMP_EQ : (a < b) ? cfam_pkg::CFAM_CMP_LT : cfam_pkg::CFAM_CMP_GT;
   endfunction : rel

   // Compare-style branch truth for each condition code
   function automatic logic exp_br(logic [2:0] c, cfam_pkg::cfam_cmp_t s);
      logic eq, lt, gt;
      logic [7:0] t;
      eq = (s == cfam_pkg::CFAM_CMP_EQ);
      lt = (s == cfam_pkg::CFAM_CMP_LT);
      gt = (s == cfam_pkg::CFAM_CMP_GT);
      t = {1'b1, !gt, gt, !lt, lt, !eq, eq, 1'b0};
      exp_br = t[c];
   endfunction : exp_br

   // ==========================================================
   // Scenarios
   task automatic t_chain(cfam_pkg::cfam_op_t fop, logic [15:0] hi, logic [15:0] hb,
      logic [9:0] ihi, logic [15:0] lo, logic [9:0] ilo, cfam_pkg::cfam_cmp_t e);
      model.issue(mk(fop, hi, hb, ihi, cfam_pkg::CFAM_BC_NONE), r);
      for (int c = 0; c < 8; c++) begin
         model.issue(mk(cfam_pkg::CFAM_OP_CHAIN_IMM, lo, 16'h0000, ilo,
                        cfam_pkg::cfam_cond_t'(3'(c))), r);
         chk(r.cmp_state, e);
         chk(r.br_valid, c != 0);
         chk(r.br_take, exp_br(3'(c), e));
         chk(r.wr_en, 1'b0);
         chk(r.always_execute_flag, 1'b0);
         chk(r.ovf_write, 1'b0);
      end
   endtask : t_chain

   task automatic t_find();
      logic [15:0] v;
      for (int i = 0; i <= 16; i++) begin
         v = (i < 16) ? ((16'h0001 << i) | (((16'h0001 << i) - 16'h0001) & 16'h5555)) : 16'h0000;
         model.issue(mk(cfam_pkg::CFAM_OP_FHSB, v, 16'hffff, 10'h3ff, cfam_pkg::CFAM_BC_EQ), r);
         chk(r.data, (i < 16) ? 16'(i) : 16'h8000);
         chk(r.wr_en, 1'b1);
         chk(r.rd, 6'h2a);
         chk(r.fm_update, 1'b1);
         chk(r.always_execute_flag, 1'b1);
         chk(r.br_take, i == 0);
         chk(r.ovf_write, 1'b0);
      end
      // Highest set bit 10 of 0480 gives index 10; lower bit 7 is ignored
      model.issue(mk(cfam_pkg::CFAM_OP_FHSB, 16'h0480, 16'h0, 10'h0,
                     cfam_pkg::CFAM_BC_NONE), r);
      chk(r.data, 16'h000a);
   endtask : t_find

   task automatic t_load();
      logic [15:0] vals [3] = '{16'h0000, 16'hbeef, 16'hffff};
      foreach (vals[k]) begin
         model.issue(mk(cfam_pkg::CFAM_OP_LIMM, vals[k], 16'h0, 10'h0, cfam_pkg::CFAM_BC_ALW), r);
         chk(r.data, vals[k]);
         chk(r.wr_en, 1'b1);
         chk(r.br_valid, 1'b0);
         chk(r.fm_update, 1'b1);
         chk(r.ovf_write, 1'b0);
      end
   endtask : t_load

   task automatic t_max();
      logic [15:0] a [4] = '{16'h8000, 16'h0001, 16'h1234, 16'h0000};
      logic [15:0] b [4] = '{16'h7fff, 16'hfffe, 16'h1234, 16'hffff};
      foreach (a[k]) begin
         model.issue(mk(cfam_pkg::CFAM_OP_MAX, a[k], b[k], 10'h0, cfam_pkg::CFAM_BC_GT), r);
         chk(r.data, (a[k] >= b[k]) ? a[k] : b[k]);
         chk(r.wr_en, 1'b1);
         chk(r.br_take, exp_br(3'h5, rel(a[k], b[k])));
         chk(r.fm_update, 1'b1);
         chk(r.always_execute_flag, 1'b1);
         chk(r.ovf_write, 1'b0);
      end
   endtask : t_max

   // Low enable holds the last result even across a new instruction
   task automatic t_freeze();
      model.issue(mk(cfam_pkg::CFAM_OP_LIMM, 16'h1357, 16'h0, 10'h0, cfam_pkg::CFAM_BC_NONE), r);
      chk(r.data, 16'h1357);
      clk_en = 1'b0;
      model.issue(mk(cfam_pkg::CFAM_OP_FHSB, 16'h0000, 16'h0, 10'h0, cfam_pkg::CFAM_BC_NONE), r);
      chk(r.data, 16'h1357);
      chk(r.wr_en, 1'b1);
      clk_en = 1'b1;
      model.issue(mk(cfam_pkg::CFAM_OP_LIMM, 16'h2468, 16'h0, 10'h0, cfam_pkg::CFAM_BC_NONE), r);
      chk(r.data, 16'h2468);
   endtask : t_freeze

   // ==========================================================
   // Closing
   task automatic end_sim();
      if (failures == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (5000) @(negedge ref_clk);
      failures++;
      end_sim();
   end

   initial begin
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      chk(res.wr_en, 1'b0);
      // Chain immediates kept at or under 1ff unless extension is wanted
      t_chain(cfam_pkg::CFAM_OP_FIRST_IMM, 16'h0123, 16'h0, 10'h123, 16'h01ff, 10'h1ff,
              cfam_pkg::CFAM_CMP_EQ);
      t_chain(cfam_pkg::CFAM_OP_FIRST_IMM, 16'h0123, 16'h0, 10'h124, 16'hffff, 10'h1ff,
              cfam_pkg::CFAM_CMP_LT);
      t_chain(cfam_pkg::CFAM_OP_FIRST_IMM, 16'hfe00, 16'h0, 10'h200, 16'h0200, 10'h200,
              cfam_pkg::CFAM_CMP_LT);
      t_chain(cfam_pkg::CFAM_OP_FIRST_IMM, 16'h0123, 16'h0, 10'h123, 16'hffff, 10'h3ff,
              cfam_pkg::CFAM_CMP_EQ);
      t_chain(cfam_pkg::CFAM_OP_FIRST_IMM, 16'h0300, 16'h0, 10'h1ff, 16'h0000, 10'h001,
              cfam_pkg::CFAM_CMP_GT);
      t_chain(cfam_pkg::CFAM_OP_FIRST_IMM, 16'h0005, 16'h0, 10'h005, 16'h0010, 10'h00f,
              cfam_pkg::CFAM_CMP_GT);
      t_chain(cfam_pkg::CFAM_OP_REG_COMPARE, 16'h8000, 16'h8000, 10'h0, 16'h0001, 10'h001,
              cfam_pkg::CFAM_CMP_EQ);
      t_chain(cfam_pkg::CFAM_OP_REG_COMPARE, 16'h8000, 16'h7fff, 10'h0, 16'h0000, 10'h001,
              cfam_pkg::CFAM_CMP_GT);
      t_find();
      t_load();
      t_max();
      t_freeze();
      end_sim();
   end
endmodule : cfam_alu_tb

// [tb/cfam_core_model.sv]
// Decoder stand-in that issues one decoded instruction and returns its result
module cfam_core_model (
   input  wire logic                   ref_clk,
   output cfam_pkg::cfam_instr_t       instr,
   input  wire cfam_pkg::cfam_result_t result
);
   timeunit 1ns;
   timeprecision 100ps;

   initial instr = '0;

   // ==========================================================
   // Issue
   // A gap cycle follows each issue so valid is never rewritten in one step
   task automatic issue(input  cfam_pkg::cfam_instr_t i,
                        output cfam_pkg::cfam_result_t r);
      @(negedge ref_clk);
      instr = i;
      @(negedge ref_clk);
      r = result;
      instr.valid = 1'b0;
   endtask : issue
endmodule : cfam_core_model
